// ===== burst_counter.sv
// two-bit burst counter with linear and interleaved order
// assumes load and advance are already qualified by the caller
`timescale 1ns/1ps
`include "burst_sram_consts.svh"

module burst_counter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire burst_sram_pkg::burst_t load_val,
    input wire logic advance,
    input wire logic interleaved,
    output burst_sram_pkg::burst_t low_next
);
    import burst_sram_pkg::*;

    burst_t base_reg;
    burst_t base_next;
    burst_t step_reg;
    burst_t step_next;

    // ------------------------------------------------------------
    // next base and step
    // ------------------------------------------------------------
    always_comb begin
        base_next = base_reg;
        step_next = step_reg;
        if (load) begin
            base_next = load_val;
            step_next = `BURST_ZERO;
        end else if (advance) begin
            step_next = burst_t'(step_reg + `BURST_STEP);
        end
    end

    // low address bits in the selected order
    always_comb begin
        if (interleaved) begin
            low_next = base_next ^ step_next;
        end else begin
            low_next = burst_t'(base_next + step_next);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_reg <= `BURST_ZERO;
            step_reg <= `BURST_ZERO;
        end else begin
            base_reg <= base_next;
            step_reg <= step_next;
        end
    end

endmodule : burst_counter

// ===== burst_sram_consts.svh
// constants for the burst sram port control block
// assumes a 36-bit word of four 9-bit lanes and a 19-bit word address
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH

`define ADDR_W 19
`define ADDR_UPPER_W 17
`define LANES 4
`define LANE_DATA_W 8
`define DATA_W 32
`define WORD_W 36
`define BURST_W 2
`define BURST_STEP 2'h1
`define BURST_ZERO 2'h0
`define ADDR_RESET 19'h00000
`define ADDR_UPPER_RESET 17'h00000
`define WORD_RESET 36'h000000000
`define LANE_NONE 4'h0
`define LANE_ALL 4'hf

`endif

// ===== burst_sram_pkg.sv
// types shared by the burst sram port control files
// assumes burst_sram_consts.svh is on the include path
`include "burst_sram_consts.svh"

package burst_sram_pkg;

    typedef logic [`LANES-1:0] lane_mask_t;
    typedef logic [`BURST_W-1:0] burst_t;
    typedef logic [`ADDR_W-1:0] word_addr_t;
    typedef logic [`WORD_W-1:0] word_t;

    // selection phase of the port
    typedef enum logic [1:0] {
        ST_DESEL = 2'b00,
        ST_LEAD = 2'b01,
        ST_ACTIVE = 2'b10
    } access_state_t;

endpackage : burst_sram_pkg

// ===== burst_sram_port_checker.sv
// pin-level checker for the burst sram port control
// assumes it is bound onto burst_sram_port_control
`timescale 1ns/1ps
`include "burst_sram_consts.svh"
module burst_sram_port_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`ADDR_UPPER_W-1:0] addr_upper,
    input wire logic addr_bit_one,
    input wire logic addr_bit_zero,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_secondary,
    input wire logic chip_sel_third_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order_interleaved,
    input wire logic dq_oe,
    input wire burst_sram_pkg::word_addr_t mem_addr,
    input wire burst_sram_pkg::lane_mask_t mem_byte_we,
    input wire logic selected
);
    import burst_sram_pkg::*;
    // ----
    // qualified requests
    // ----
    wire chip_ok = !chip_sel_primary_n && chip_sel_secondary && !chip_sel_third_n;
    wire p_take = !processor_addr_strobe_n && !chip_sel_primary_n;
    wire c_take = !controller_addr_strobe_n && !p_take;
    wire no_stb = processor_addr_strobe_n && controller_addr_strobe_n;
    wire [`ADDR_W-1:0] pin_addr = {addr_upper, addr_bit_one, addr_bit_zero};
    wire [1:0] low_bits = mem_addr[1:0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_oe_off: assert property (output_enable_n |-> !dq_oe)
        else $error("drive with oe off");
    chk_lead_float: assert property ($rose(selected) |-> !dq_oe)
        else $error("drive in lead clock");
    chk_desel_float: assert property (!selected |-> !dq_oe)
        else $error("drive while deselected");
    chk_load_addr: assert property ((p_take || c_take) && chip_ok |=>
        selected && mem_addr == $past(pin_addr)) else $error("load address");
    chk_desel_load: assert property (c_take && !chip_ok |=> !selected)
        else $error("selected on bad chip select");
    chk_proc_ignored: assert property (!processor_addr_strobe_n && chip_sel_primary_n
        && controller_addr_strobe_n && burst_advance_n |=> $stable(mem_addr)
        && $stable(selected)) else $error("address moved");
    chk_both_strobes: assert property (p_take && !controller_addr_strobe_n |=>
        mem_byte_we == `LANE_NONE) else $error("write on processor edge");
    chk_global_write: assert property (c_take && chip_ok && !global_write_n |=>
        mem_byte_we == `LANE_ALL) else $error("global write lanes");
    chk_linear_step: assert property (selected && no_stb && !burst_advance_n
        && !burst_order_interleaved |=> selected && low_bits == $past(low_bits) + 2'h1)
        else $error("linear step");
    cover property (p_take && chip_ok);
    cover property (c_take && chip_ok && !global_write_n);
    cover property (selected && no_stb && !burst_advance_n);
endmodule : burst_sram_port_checker

bind burst_sram_port_control burst_sram_port_checker chk_i (
    .clk, .resetn, .addr_upper, .addr_bit_one, .addr_bit_zero, .chip_sel_primary_n,
    .chip_sel_secondary, .chip_sel_third_n, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .global_write_n, .output_enable_n,
    .burst_order_interleaved, .dq_oe, .mem_addr, .mem_byte_we, .selected);

// ===== burst_sram_port_control.sv
// control side of a flow-through synchronous burst sram port
// assumes an external array that writes on mem_byte_we at the clock edge
// and reads mem_addr combinationally back on mem_rdata
`timescale 1ns/1ps
`include "burst_sram_consts.svh"

// Notes on behaviour
// - all synchronous inputs registered each rising edge
// - load address on strobe with chip selected
// - low two address bits load burst counter
// - advance low steps the burst counter
// - lane write needs lane select and gate
// - global write writes all lanes
// - selected when cs1 low, cs2 high, cs3 low
// - processor strobe ignored while cs1 high
// - chip selects only evaluated at address load
// - output enable asynchronously sets data direction
// - first read clock after deselect stays undriven
// - both strobes low: processor strobe wins
// - order pin low linear, high interleaved
// - pins float during write data and deselect
// - read data from address of previous edge
module burst_sram_port_control (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`ADDR_UPPER_W-1:0] addr_upper,
    input wire logic addr_bit_one,
    input wire logic addr_bit_zero,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_secondary,
    input wire logic chip_sel_third_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic byte_write_select_lane0_n,
    input wire logic byte_write_select_lane1_n,
    input wire logic byte_write_select_lane2_n,
    input wire logic byte_write_select_lane3_n,
    input wire logic byte_write_gate_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order_interleaved,
    input wire logic [`DATA_W-1:0] dq_in,
    output logic [`DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [`LANES-1:0] parity_io_in,
    output logic [`LANES-1:0] parity_io_out,
    output logic parity_io_oe,
    output burst_sram_pkg::word_addr_t mem_addr,
    output burst_sram_pkg::lane_mask_t mem_byte_we,
    output burst_sram_pkg::word_t mem_wdata,
    input wire burst_sram_pkg::word_t mem_rdata,
    output logic selected
);
    import burst_sram_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    access_state_t state_reg;
    access_state_t state_next;
    word_addr_t addr_reg;
    word_addr_t addr_next;
    lane_mask_t we_reg;
    lane_mask_t we_next;
    word_t wdata_reg;
    word_t wdata_next;
    logic drive_reg;
    logic drive_next;
    logic [`ADDR_UPPER_W-1:0] upper_reg;
    logic [`ADDR_UPPER_W-1:0] upper_next;
    logic sel_reg;
    logic sel_next;

    logic chip_ok;
    logic proc_start;
    logic ctrl_start;
    logic load;
    logic load_sel;
    logic advance;
    logic write_any;
    logic write_cycle;
    lane_mask_t lane_sel_n;
    lane_mask_t lane_we;
    burst_t low_next;
    burst_t low_load;

    // ------------------------------------------------------------
    // sampled strobe decode
    // ------------------------------------------------------------
    // all three selects must be active at the same edge
    assign chip_ok = !chip_sel_primary_n && chip_sel_secondary && !chip_sel_third_n;

    // processor strobe only counts with cs1 low
    assign proc_start = !processor_addr_strobe_n && !chip_sel_primary_n;

    // controller strobe only acts when processor strobe does not
    assign ctrl_start = !controller_addr_strobe_n && !proc_start;

    // any recognised strobe ends the current burst; an address loads only with chip_ok
    assign load = proc_start || ctrl_start;

    // selection is decided only on a load edge
    assign load_sel = load && chip_ok;

    // advance only moves an established, selected burst
    assign advance = !load && !burst_advance_n && (state_reg != ST_DESEL);

    assign low_load = {addr_bit_one, addr_bit_zero};

    // ------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------
    burst_counter u_burst_counter (
        .clk(clk),
        .resetn(resetn),
        .load(load_sel),
        .load_val(low_load),
        .advance(advance),
        .interleaved(burst_order_interleaved),
        .low_next(low_next)
    );

    // ------------------------------------------------------------
    // lane write enables
    // ------------------------------------------------------------
    assign lane_sel_n = {byte_write_select_lane3_n, byte_write_select_lane2_n,
                         byte_write_select_lane1_n, byte_write_select_lane0_n};

    // per lane: global write wins, else lane select qualified by gate
    genvar lane;
    generate
        for (lane = 0; lane < `LANES; lane = lane + 1) begin : g_lane
            assign lane_we[lane] = !global_write_n
                                   || (!byte_write_gate_n && !lane_sel_n[lane]);
        end
    endgenerate

    assign write_any = |lane_we;

    // ------------------------------------------------------------
    // selection state
    // ------------------------------------------------------------
    // lead phase marks the first clock after leaving deselect
    always_comb begin
        state_next = state_reg;
        if (load) begin
            if (!chip_ok) begin
                state_next = ST_DESEL;
            end else if (state_reg == ST_DESEL) begin
                state_next = ST_LEAD;
            end else begin
                state_next = ST_ACTIVE;
            end
        end else begin
            case (state_reg)
                ST_DESEL: state_next = ST_DESEL;
                ST_LEAD: state_next = ST_ACTIVE;
                ST_ACTIVE: state_next = ST_ACTIVE;
                default: state_next = ST_DESEL;
            endcase
        end
    end

    // register the selection phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_DESEL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // selected flag
    // ------------------------------------------------------------
    // selected pin comes from its own flop, not a state decode
    always_comb begin
        sel_next = (state_next != ST_DESEL);
    end

    // register the selected flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // ------------------------------------------------------------
    // address capture
    // ------------------------------------------------------------
    // write data cycle: selected, not a processor strobe edge, a lane enabled
    assign write_cycle = (state_next != ST_DESEL) && !proc_start && write_any;

    // upper address only moves on a selecting load
    always_comb begin
        upper_next = upper_reg;
        if (load_sel) begin
            upper_next = addr_upper;
        end
    end

    // register the upper address
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upper_reg <= `ADDR_UPPER_RESET;
        end else begin
            upper_reg <= upper_next;
        end
    end

    // word address follows the burst counter while selected
    always_comb begin
        addr_next = addr_reg;
        if (state_next != ST_DESEL) begin
            addr_next = {upper_next, low_next};
        end
    end

    // register the word address
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= `ADDR_RESET;
        end else begin
            addr_reg <= addr_next;
        end
    end

    // ------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------
    // processor strobe edges are read starts; writes come later
    always_comb begin
        we_next = `LANE_NONE;
        if (state_next != ST_DESEL && !proc_start) begin
            we_next = lane_we;
        end
    end

    // register the lane enables, one cycle per write edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            we_reg <= `LANE_NONE;
        end else begin
            we_reg <= we_next;
        end
    end

    // write word held until the next accepted write edge
    always_comb begin
        wdata_next = wdata_reg;
        if (write_cycle) begin
            wdata_next = {parity_io_in, dq_in};
        end
    end

    // register the write word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdata_reg <= `WORD_RESET;
        end else begin
            wdata_reg <= wdata_next;
        end
    end

    // ------------------------------------------------------------
    // read drive qualification
    // ------------------------------------------------------------
    // drive only in a selected read past the lead clock
    always_comb begin
        drive_next = 1'b0;
        if (state_next == ST_ACTIVE) begin
            drive_next = !(!proc_start && write_any);
        end
    end

    // register the read drive qualifier
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // enable joins the registered phase with the async oe pin
    assign dq_oe = drive_reg && !output_enable_n;
    assign parity_io_oe = drive_reg && !output_enable_n;

    // flow-through: array output at the registered address
    assign dq_out = mem_rdata[`DATA_W-1:0];
    assign parity_io_out = mem_rdata[`WORD_W-1:`DATA_W];

    assign mem_addr = addr_reg;
    assign mem_byte_we = we_reg;
    assign mem_wdata = wdata_reg;
    assign selected = sel_reg;

endmodule : burst_sram_port_control

// ===== mem_array_model.sv
// behavioural word array behind the port
// assumes registered lane enables and a combinational read
`timescale 1ns/1ps
`include "burst_sram_consts.svh"
module mem_array_model
    import burst_sram_pkg::*;
(
    input wire logic clk,
    input wire word_addr_t mem_addr,
    input wire lane_mask_t mem_byte_we,
    input wire word_t mem_wdata,
    output word_t mem_rdata
);
    word_t store [word_addr_t];
    int wr_cnt = 0;
    // unwritten words read a pattern, never zero
    function automatic word_t rd(input word_addr_t a);
        return store.exists(a) ? store[a] : {~a, 17'h1aaaa};
    endfunction : rd
    // lane writes land at the edge after the enable
    always @(posedge clk) begin
        word_t w;
        w = rd(mem_addr);
        for (int i = 0; i < `LANES; i++) begin
            if (mem_byte_we[i]) begin
                w[8*i +: 8] = mem_wdata[8*i +: 8];
                w[32+i] = mem_wdata[32+i];
            end
        end
        if (|mem_byte_we) begin
            store[mem_addr] = w;
            wr_cnt++;
        end
    end
    always @(mem_addr, wr_cnt) mem_rdata = rd(mem_addr);
endmodule : mem_array_model

// ===== tb_burst_sram_port_control.sv
// self-checking bench for the burst sram port control
// assumes mem_array_model as the array and the bound checker
`timescale 1ns/1ps
`include "burst_sram_consts.svh"
module tb_burst_sram_port_control;
    import burst_sram_pkg::*;
    // ----
    // stimulus and observed signals
    // ----
    logic clk = 1'h0, resetn = 1'h0, order = 1'h0, oe_n = 1'h1, dq_oe, poe, selected;
    logic pstb_n = 1'h1, cstb_n = 1'h1, step_n = 1'h1, gate_n = 1'h1, all_wr_n = 1'h1;
    logic sel_p_n = 1'h1, sel_s = 1'h0, sel_t_n = 1'h1;
    logic [3:0] lane_n = 4'hf, pin = 4'h0, pout;
    logic [31:0] din = 32'h0, dout;
    logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h6};
    word_addr_t addr = `ADDR_RESET, mem_addr;
    lane_mask_t we;
    word_t wdata, rdata;
    int miscompares = 0, checked = 0;
    always #2 clk = ~clk;
    burst_sram_port_control uut (
        .clk(clk), .resetn(resetn), .addr_upper(addr[18:2]), .addr_bit_one(addr[1]),
        .addr_bit_zero(addr[0]), .chip_sel_primary_n(sel_p_n), .chip_sel_secondary(sel_s),
        .chip_sel_third_n(sel_t_n), .processor_addr_strobe_n(pstb_n),
        .controller_addr_strobe_n(cstb_n), .burst_advance_n(step_n),
        .byte_write_select_lane0_n(lane_n[0]), .byte_write_select_lane1_n(lane_n[1]),
        .byte_write_select_lane2_n(lane_n[2]), .byte_write_select_lane3_n(lane_n[3]),
        .byte_write_gate_n(gate_n), .global_write_n(all_wr_n), .output_enable_n(oe_n),
        .burst_order_interleaved(order), .dq_in(din), .dq_out(dout), .dq_oe(dq_oe),
        .parity_io_in(pin), .parity_io_out(pout), .parity_io_oe(poe), .mem_addr(mem_addr),
        .mem_byte_we(we), .mem_wdata(wdata), .mem_rdata(rdata), .selected(selected));
    mem_array_model mem_i (.clk(clk), .mem_addr(mem_addr), .mem_byte_we(we),
        .mem_wdata(wdata), .mem_rdata(rdata));
    // ----
    // shared drive and compare
    // ----
    function automatic word_t pat(input int k);
        return {k[3:0], 28'h5a5a5a5, k[3:0]};
    endfunction : pat
    task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // strobes {proc, ctl, step}, selects {p_n, s, t_n}; returns one edge later
    task automatic go(input logic [2:0] s, input logic [2:0] cs, input word_addr_t a);
        {pstb_n, cstb_n, step_n} = s;
        {sel_p_n, sel_s, sel_t_n} = cs;
        addr = a;
        @(negedge clk);
    endtask : go
    task automatic t_write();
        all_wr_n = 1'h0;
        oe_n = 1'h0;
        for (int k = 0; k < 4; k++) begin
            {pin, din} = pat(k);
            go(3'h5, 3'h2, {17'h00041, k[1:0]});
            cmp("global we", `LANE_ALL, we);
            cmp("write word", pat(k), wdata);
            cmp("write drive", 1'h0, dq_oe);
            cmp("parity float", 1'h0, poe);
        end
        all_wr_n = 1'h1;
        gate_n = 1'h0;
        lane_n = 4'ha;
        go(3'h5, 3'h2, 19'h00108);
        cmp("lane we", 4'h5, we);
        gate_n = 1'h1;
        go(3'h5, 3'h2, 19'h00109);
        cmp("ungated we", `LANE_NONE, we);
        lane_n = 4'hf;
    endtask : t_write
    task automatic t_desel();
        foreach (bad[i]) begin
            go(3'h5, bad[i], 19'h00300);
            cmp("selected", 1'h0, selected);
            cmp("idle drive", 1'h0, dq_oe);
        end
    endtask : t_desel
    task automatic t_burst(input logic o, input logic [1:0] b);
        logic [1:0] e;
        order = o;
        go(3'h3, 3'h2, {17'h00041, b});
        for (int j = 0; j < 4; j++) begin
            e = o ? b ^ j[1:0] : b + j[1:0];
            cmp("burst addr", {17'h00041, e}, mem_addr);
            cmp("read data", pat(e), {pout, dout});
            cmp("read drive", j != 0, dq_oe);
            cmp("held select", 1'h1, selected);
            go(3'h6, 3'h0, `ADDR_RESET);
        end
    endtask : t_burst
    task automatic t_ignore();
        go(3'h3, 3'h6, 19'h7ffff);
        cmp("ignored load", 19'h00105, mem_addr);
        all_wr_n = 1'h0;
        go(3'h1, 3'h2, 19'h00106);
        all_wr_n = 1'h1;
        cmp("both strobes", 19'h00106, mem_addr);
        cmp("proc no write", `LANE_NONE, we);
        cmp("oe low drive", 1'h1, dq_oe);
        cmp("oe low parity", 1'h1, poe);
        oe_n = 1'h1;
        #1;
        cmp("oe high float", 1'h0, dq_oe);
        cmp("oe high parity", 1'h0, poe);
        @(negedge clk);
        oe_n = 1'h0;
        gate_n = 1'h0;
        lane_n = 4'he;
        go(3'h7, 3'h0, 19'h7ffff);
        cmp("proc write we", 4'h1, we);
        cmp("proc write word", pat(3), wdata);
        cmp("proc write drive", 1'h0, dq_oe);
        gate_n = 1'h1;
        lane_n = 4'hf;
    endtask : t_ignore
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge clk);
        resetn = 1'h1;
        t_write();
        t_desel();
        t_burst(1'h0, 2'h3);
        t_desel();
        t_burst(1'h1, 2'h1);
        t_ignore();
        finish_test();
    end
    // watchdog well past the expected run
    initial begin
        #4000;
        miscompares++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : tb_burst_sram_port_control
